// File: core/sscr_pkg.sv
package sscr_pkg;
  // Clock and unit timing
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CHAR_TIME_MS    = 100;
  localparam int unsigned UNITS_PER_CHAR  = 11;
  localparam int unsigned UNIT_CYCLES     = (CLK_HZ / 1000 * CHAR_TIME_MS) / UNITS_PER_CHAR;
  localparam int unsigned HALF_UNIT       = UNIT_CYCLES / 2;
  localparam int unsigned CODE_LEVELS     = 8;
  localparam int unsigned INFO_LEVELS     = 7;
  // Printer geometry and operation step length
  localparam int unsigned LINE_COLUMNS    = 72;
  localparam int unsigned STEP_CYCLES     = 4;
  // Function codes
  localparam logic [6:0]  CODE_LF         = 7'h0A;
  localparam logic [6:0]  CODE_CR         = 7'h0D;
  localparam logic [6:0]  CODE_BELL       = 7'h07;
  localparam logic [6:0]  CODE_DEL        = 7'h7F;
  localparam logic [6:0]  CODE_FIRST_GFX  = 7'h20;
  // Receiver states
  typedef enum logic [2:0] {
    SSCR_IDLE  = 3'b000,
    SSCR_START = 3'b001,
    SSCR_DATA  = 3'b011,
    SSCR_STOP1 = 3'b010,
    SSCR_STOP2 = 3'b110
  } sscr_rx_e;
  // Operation sequence states
  typedef enum logic [2:0] {
    SSCR_OP_WAIT  = 3'b000,
    SSCR_OP_LATCH = 3'b001,
    SSCR_OP_DEC   = 3'b011,
    SSCR_OP_PRINT = 3'b010,
    SSCR_OP_SPACE = 3'b110,
    SSCR_OP_FEED  = 3'b111
  } sscr_op_e;
endpackage

// File: core/sscr_receiver.sv
`timescale 1ns/1ns
// Notes on behaviour
// - A spacing start unit after idle marking begins each character.
// - Two marking stop units end each character before the next.
// - Eleven equal units: start, eight levels, two stops.
// - Eighth level normally marking; seven information levels, 128 codes.
// - Optional mode: eighth level is even parity over marking units.
// - Unit time is 100 ms over 11 units.
// - Any idle time between characters is accepted.
// - Receiver rests once the first stop unit samples marking, resynchronises only on next start.
// - Last information unit captured before second stop unit ends.
// - Adjustable phase offset from start detect to sample instants.
// - Steps: selection, latch, decode, print, spacing, line feed.
// - Nonprinting functions suppress the print step.
// - Each printed graphic short of the last column advances one position right.
// - No advance for functions or at end of line.
// - Line feed only for line feed code, exactly one line.
// - Carriage return returns position via spacing path.
// - Unassigned function codes do nothing; decoder easy to extend.
// - Levels one to seven carry the seven-bit code.
// - Idle line marks; sustained spacing means open line.
// - Sample each unit near its middle.

// ****************************************
// Buffer FIFO
// ****************************************
module sscr_fifo #(
  parameter int unsigned WIDTH = 7,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sscr_fifo

// ****************************************
// Receiver and printer sequencer
// ****************************************
module sscr_receiver
  import sscr_pkg::*;
#(
  parameter int unsigned UNIT_LEN  = sscr_pkg::UNIT_CYCLES,
  parameter int unsigned COLUMNS   = sscr_pkg::LINE_COLUMNS,
  parameter int unsigned FIFO_DEPTH = 8,
  parameter int unsigned OPEN_UNITS = 22
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        line_mark_in,
  input  wire logic        parity_mode_in,
  input  wire logic signed [15:0] phase_offset_in,
  output logic             char_valid_out,
  output logic [6:0]       char_code_out,
  output logic             frame_error_out,
  output logic             parity_error_out,
  output logic             overrun_out,
  output logic             open_line_out,
  output logic             rx_busy_out,
  output logic             print_strobe_out,
  output logic [6:0]       print_code_out,
  output logic             space_strobe_out,
  output logic             carriage_return_out,
  output logic             line_feed_out,
  output logic             bell_out,
  output logic [6:0]       column_out
);
  import sscr_pkg::*;

  sscr_rx_e         rx_state;
  logic [19:0]      unit_cnt;
  logic [3:0]       bit_idx;
  logic [7:0]       shreg;
  logic [19:0]      first_sample;
  logic [23:0]      open_cnt;
  logic             fifo_in_valid;
  logic             fifo_in_ready;
  logic [6:0]       fifo_in_data;
  logic             fifo_out_valid;
  logic             fifo_out_ready;
  logic [6:0]       fifo_out_data;

  // Sample point: mid-unit plus signed tuning offset, clamped
  always_comb begin
    automatic int signed pt;
    pt = int'(UNIT_LEN / 2) + int'(phase_offset_in);
    if (pt < 1) begin
      pt = 1;
    end else if (pt > int'(UNIT_LEN) - 1) begin
      pt = int'(UNIT_LEN) - 1;
    end
    first_sample = 20'(pt);
  end

  // ****************************************
  // Start-stop receiver
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rx_state         <= SSCR_IDLE;
      unit_cnt         <= '0;
      bit_idx          <= '0;
      shreg            <= '0;
      fifo_in_valid    <= 1'b0;
      fifo_in_data     <= '0;
      frame_error_out  <= 1'b0;
      parity_error_out <= 1'b0;
      overrun_out      <= 1'b0;
      char_valid_out   <= 1'b0;
      char_code_out    <= '0;
      rx_busy_out      <= 1'b0;
    end else begin
      fifo_in_valid    <= 1'b0;
      char_valid_out   <= 1'b0;
      frame_error_out  <= 1'b0;
      parity_error_out <= 1'b0;
      overrun_out      <= 1'b0;
      unit_cnt         <= unit_cnt + 1'b1;
      case (rx_state)
        SSCR_IDLE: begin
          rx_busy_out <= 1'b0;
          unit_cnt    <= '0;
          if (!line_mark_in) begin
            rx_state    <= SSCR_START;
            rx_busy_out <= 1'b1;
          end
        end
        SSCR_START: begin
          if (unit_cnt == first_sample) begin
            unit_cnt <= '0;
            bit_idx  <= '0;
            // Glitch rejection: start must still be spacing
            rx_state <= line_mark_in ? SSCR_IDLE : SSCR_DATA;
          end
        end
        SSCR_DATA: begin
          if (unit_cnt == 20'(UNIT_LEN - 1)) begin
            unit_cnt <= '0;
            shreg    <= {line_mark_in, shreg[7:1]};
            bit_idx  <= bit_idx + 1'b1;
            if (bit_idx == 4'(CODE_LEVELS - 1)) begin
              rx_state <= SSCR_STOP1;
            end
          end
        end
        SSCR_STOP1: begin
          if (unit_cnt == 20'(UNIT_LEN - 1)) begin
            unit_cnt <= '0;
            if (!line_mark_in) begin
              frame_error_out <= 1'b1;
              rx_state        <= SSCR_IDLE;
            end else if (parity_mode_in && ^shreg) begin
              parity_error_out <= 1'b1;
              rx_state         <= SSCR_STOP2;
            end else begin
              char_code_out  <= shreg[6:0];
              char_valid_out <= 1'b1;
              fifo_in_data   <= shreg[6:0];
              fifo_in_valid  <= fifo_in_ready;
              overrun_out    <= !fifo_in_ready;
              rx_state       <= SSCR_STOP2;
            end
          end
        end
        SSCR_STOP2: begin
          if (line_mark_in) begin
            rx_state <= SSCR_IDLE;
          end
        end
        default: begin
          rx_state <= SSCR_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Open line watch
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      open_cnt      <= '0;
      open_line_out <= 1'b0;
    end else begin
      if (line_mark_in) begin
        open_cnt      <= '0;
        open_line_out <= 1'b0;
      end else if (open_cnt == 24'(UNIT_LEN * OPEN_UNITS)) begin
        open_line_out <= 1'b1;
      end else begin
        open_cnt <= open_cnt + 1'b1;
      end
    end
  end

  sscr_fifo #(
    .WIDTH (7),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in_data),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data)
  );

  // ****************************************
  // Operation sequencer
  // ****************************************
  sscr_op_e   op_state;
  logic [6:0] op_code;
  logic       op_graphic;
  logic       op_lf;
  logic       op_cr;
  logic [2:0] step_cnt;

  assign fifo_out_ready = (op_state == SSCR_OP_WAIT);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      op_state            <= SSCR_OP_WAIT;
      op_code             <= '0;
      op_graphic          <= 1'b0;
      op_lf               <= 1'b0;
      op_cr               <= 1'b0;
      step_cnt            <= '0;
      print_strobe_out    <= 1'b0;
      print_code_out      <= '0;
      space_strobe_out    <= 1'b0;
      carriage_return_out <= 1'b0;
      line_feed_out       <= 1'b0;
      bell_out            <= 1'b0;
      column_out          <= '0;
    end else begin
      print_strobe_out    <= 1'b0;
      space_strobe_out    <= 1'b0;
      carriage_return_out <= 1'b0;
      line_feed_out       <= 1'b0;
      bell_out            <= 1'b0;
      step_cnt            <= step_cnt + 1'b1;
      case (op_state)
        SSCR_OP_WAIT: begin
          step_cnt <= '0;
          if (fifo_out_valid) begin
            op_code  <= fifo_out_data;
            op_state <= SSCR_OP_LATCH;
          end
        end
        SSCR_OP_LATCH: begin
          op_graphic <= (op_code >= CODE_FIRST_GFX) && (op_code != CODE_DEL);
          op_state   <= SSCR_OP_DEC;
        end
        SSCR_OP_DEC: begin
          op_lf    <= (op_code == CODE_LF);
          op_cr    <= (op_code == CODE_CR);
          bell_out <= (op_code == CODE_BELL);
          op_state <= SSCR_OP_PRINT;
          step_cnt <= '0;
        end
        SSCR_OP_PRINT: begin
          if (step_cnt == 3'd0 && op_graphic) begin
            print_strobe_out <= 1'b1;
            print_code_out   <= op_code;
          end
          if (step_cnt == 3'(STEP_CYCLES - 1)) begin
            op_state <= SSCR_OP_SPACE;
            step_cnt <= '0;
          end
        end
        SSCR_OP_SPACE: begin
          if (step_cnt == 3'd0) begin
            if (op_cr) begin
              carriage_return_out <= 1'b1;
              column_out          <= '0;
            end else if (op_graphic && column_out != 7'(COLUMNS - 1)) begin
              space_strobe_out <= 1'b1;
              column_out       <= column_out + 1'b1;
            end
          end
          if (step_cnt == 3'(STEP_CYCLES - 1)) begin
            op_state <= SSCR_OP_FEED;
            step_cnt <= '0;
          end
        end
        SSCR_OP_FEED: begin
          line_feed_out <= op_lf;
          op_state      <= SSCR_OP_WAIT;
        end
        default: begin
          op_state <= SSCR_OP_WAIT;
        end
      endcase
    end
  end
endmodule // sscr_receiver

// File: test/sscr_rx_monitor.sv
`timescale 1ns/1ns
// ****************************************
// Receiver port checks
// ****************************************
module sscr_rx_monitor
  import sscr_pkg::*;
#(
  parameter int unsigned UNIT_LEN   = 20,
  parameter int unsigned COLUMNS    = 72,
  parameter int unsigned OPEN_UNITS = 22
) (
  input wire logic               clk_sys_in,
  input wire logic               rst_in,
  input wire logic               line_mark_in,
  input wire logic               parity_mode_in,
  input wire logic signed [15:0] phase_offset_in,
  input wire logic               char_valid_out,
  input wire logic [6:0]         char_code_out,
  input wire logic               frame_error_out,
  input wire logic               parity_error_out,
  input wire logic               overrun_out,
  input wire logic               open_line_out,
  input wire logic               rx_busy_out,
  input wire logic               print_strobe_out,
  input wire logic [6:0]         print_code_out,
  input wire logic               space_strobe_out,
  input wire logic               carriage_return_out,
  input wire logic               line_feed_out,
  input wire logic               bell_out,
  input wire logic [6:0]         column_out
);
  localparam int REST_MAX = 4;
  int unsigned busy_cnt;
  int unsigned sp_cnt;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) busy_cnt <= 0;
    // Restart on a framing error, a new start may follow at once
    else busy_cnt <= (rx_busy_out && !frame_error_out) ? busy_cnt + 1 : 0;
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) sp_cnt <= 0;
    else sp_cnt <= line_mark_in ? 0 : sp_cnt + 1;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  chk_start_spacing: assert property ($rose(rx_busy_out) |-> !$past(line_mark_in))
    else $error("busy rose on a marking line");
  chk_frame_len: assert property ((char_valid_out || frame_error_out || parity_error_out) |->
    (busy_cnt > 8 * UNIT_LEN) && (busy_cnt < 10 * UNIT_LEN)) else $error("character length wrong");
  chk_rest_after: assert property (char_valid_out |-> ##[1:REST_MAX] !rx_busy_out)
    else $error("receiver did not come to rest");
  chk_err_excl: assert property ((frame_error_out || parity_error_out) |-> !char_valid_out)
    else $error("bad character delivered");
  chk_col_step: assert property ($changed(column_out) && column_out != 7'h00 |->
    column_out == $past(column_out) + 7'h01) else $error("column moved by other than one");
  chk_col_limit: assert property (column_out < COLUMNS)
    else $error("column past end of line");
  chk_cr_home: assert property (carriage_return_out |-> ##[0:2] column_out == 7'h00)
    else $error("return did not home column");
  chk_lf_code: assert property (line_feed_out |-> char_code_out == CODE_LF && !print_strobe_out)
    else $error("line feed for wrong code");
  chk_print_gfx: assert property (print_strobe_out |->
    print_code_out >= CODE_FIRST_GFX && print_code_out != CODE_DEL) else $error("function printed");
  chk_open_line: assert property ($rose(open_line_out) |-> sp_cnt + 2 >= UNIT_LEN * OPEN_UNITS)
    else $error("open line flagged early");
  chk_print_space: assert property (print_strobe_out && column_out < COLUMNS - 1 |->
    ##[1:8] space_strobe_out) else $error("no advance after print");
  chk_ovr_with_char: assert property (overrun_out |-> char_valid_out)
    else $error("overrun without a received character");
  cover property (char_valid_out);
  cover property (frame_error_out);
  cover property (line_feed_out);
endmodule // sscr_rx_monitor

bind sscr_receiver sscr_rx_monitor #(.UNIT_LEN(UNIT_LEN), .COLUMNS(COLUMNS), .OPEN_UNITS(OPEN_UNITS))
  sscr_rx_monitor_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .line_mark_in(line_mark_in),
  .parity_mode_in(parity_mode_in), .phase_offset_in(phase_offset_in), .char_valid_out(char_valid_out),
  .char_code_out(char_code_out), .frame_error_out(frame_error_out), .parity_error_out(parity_error_out),
  .overrun_out(overrun_out), .open_line_out(open_line_out), .rx_busy_out(rx_busy_out),
  .print_strobe_out(print_strobe_out), .print_code_out(print_code_out), .space_strobe_out(space_strobe_out),
  .carriage_return_out(carriage_return_out), .line_feed_out(line_feed_out), .bell_out(bell_out),
  .column_out(column_out));

// File: test/sscr_line_tx.sv
`timescale 1ns/1ns
// ****************************************
// Keyboard side line sender
// ****************************************
module sscr_line_tx #(
  parameter int unsigned UNIT_LEN = 20
) (
  input  wire logic clk_sys_in,
  output logic      line_mark_out
);
  initial line_mark_out = 1'b1;
  task automatic hold(input logic lvl, input int unsigned units);
    line_mark_out = lvl;
    repeat (units * UNIT_LEN) @(negedge clk_sys_in);
  endtask
  // start, levels one to eight, two stops
  task automatic send(input logic [6:0] code, input logic lvl8, input logic stop1);
    hold(1'b0, 1);
    for (int i = 0; i < 7; i++) hold(code[i], 1);
    hold(lvl8, 1);
    hold(stop1, 1);
    hold(1'b1, 1);
  endtask
endmodule // sscr_line_tx

// File: test/start_stop_char_receiver_tb_top.sv
`timescale 1ns/1ns
// ****************************************
// Receiver testbench
// ****************************************
module start_stop_char_receiver_tb_top;
  import sscr_pkg::*;
  localparam int unsigned UNIT = 20;
  logic               clk_sys_in = 1'b0;
  logic               rst_in = 1'b1;
  logic               line_mark;
  logic               parity_mode = 1'b0;
  logic signed [15:0] phase_offset = 16'sh0000;
  logic               ev_clr = 1'b1;
  logic [7:0]         ev;
  logic               valid, ferr, perr, ovr, open_line, busy, prn, spc, cr, lf, bell;
  logic [6:0]         code, pcode, col;
  int                 num_errors = 0;
  int                 total_checks = 0;
  int unsigned        cyc = 0;
  int unsigned        valid_cyc = 0;
  int unsigned        start_cyc = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  sscr_line_tx #(.UNIT_LEN(UNIT)) sscr_line_tx_inst (.clk_sys_in(clk_sys_in), .line_mark_out(line_mark));
  sscr_receiver #(.UNIT_LEN(UNIT), .COLUMNS(4)) sscr_receiver_inst (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .line_mark_in(line_mark), .parity_mode_in(parity_mode),
    .phase_offset_in(phase_offset), .char_valid_out(valid), .char_code_out(code),
    .frame_error_out(ferr), .parity_error_out(perr), .overrun_out(ovr), .open_line_out(open_line),
    .rx_busy_out(busy), .print_strobe_out(prn), .print_code_out(pcode), .space_strobe_out(spc),
    .carriage_return_out(cr), .line_feed_out(lf), .bell_out(bell), .column_out(col));
  // Sticky record of event pulses
  always @(posedge clk_sys_in) begin
    if (ev_clr) ev <= 8'h00;
    else ev <= ev | {valid, prn, spc, cr, lf, bell, ferr, perr};
  end
  // Cycle stamp of the last character delivery
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (valid) valid_cyc <= cyc;
  end
  task automatic check_cyc(input int unsigned got, input int unsigned exp);
    total_checks++;
    if (got != exp) begin
      num_errors++;
      $display("[ERR] %0t delay %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic check_ev(input logic [7:0] exp);
    total_checks++;
    if (ev !== exp) begin
      num_errors++;
      $display("[ERR] %0t events %h expected %h", $time, ev, exp);
    end
  endtask
  task automatic check_code(input logic [6:0] got, input logic [6:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic clear_ev;
    ev_clr = 1'b1;
    @(negedge clk_sys_in);
    ev_clr = 1'b0;
  endtask
  task automatic rx(input logic [6:0] c, input logic lvl8, input logic stop1);
    clear_ev();
    start_cyc = cyc;
    sscr_line_tx_inst.send(c, lvl8, stop1);
    repeat (2 * UNIT) @(negedge clk_sys_in);
  endtask
  task automatic t_graphic;
    rx(7'h41, 1'b1, 1'b1);
    check_ev(8'hE0);
    check_code(code, 7'h41);
    check_code(pcode, 7'h41);
    check_code(col, 7'h01);
  endtask
  task automatic t_functions;
    logic [6:0] fc [5] = '{7'h0A, 7'h07, 7'h01, 7'h7F, 7'h0D};
    logic [7:0] fe [5] = '{8'h88, 8'h84, 8'h80, 8'h80, 8'h90};
    for (int i = 0; i < 5; i++) begin
      rx(fc[i], 1'b1, 1'b1);
      check_ev(fe[i]);
      check_code(col, (i == 4) ? 7'h00 : 7'h01);
    end
  endtask
  task automatic t_phase;
    phase_offset = 16'sh0008;
    rx(7'h0A, 1'b1, 1'b1);
    check_ev(8'h88);
    check_cyc(valid_cyc - start_cyc, 9 * UNIT + UNIT / 2 + 8 + 2);
    phase_offset = -16'sh0008;
    rx(7'h07, 1'b1, 1'b1);
    check_ev(8'h84);
    check_cyc(valid_cyc - start_cyc, 9 * UNIT + UNIT / 2 - 8 + 2);
    phase_offset = 16'sh0000;
  endtask
  task automatic t_back_to_back;
    clear_ev();
    sscr_line_tx_inst.send(7'h55, 1'b1, 1'b1);
    sscr_line_tx_inst.send(7'h2A, 1'b1, 1'b1);
    repeat (2 * UNIT) @(negedge clk_sys_in);
    check_code(code, 7'h2A);
    check_code(col, 7'h02);
  endtask
  task automatic t_end_of_line;
    rx(7'h42, 1'b1, 1'b1);
    check_ev(8'hE0);
    rx(7'h43, 1'b1, 1'b1);
    check_ev(8'hC0);
    check_code(col, 7'h03);
  endtask
  task automatic t_frame;
    rx(7'h44, 1'b1, 1'b0);
    check_ev(8'h02);
    check_code(code, 7'h43);
  endtask
  task automatic t_parity;
    parity_mode = 1'b1;
    rx(7'h07, 1'b1, 1'b1);
    check_ev(8'h84);
    rx(7'h07, 1'b0, 1'b1);
    check_ev(8'h01);
    parity_mode = 1'b0;
  endtask
  task automatic t_open;
    sscr_line_tx_inst.hold(1'b0, 24);
    check_bit(open_line, 1'b1);
    sscr_line_tx_inst.hold(1'b1, 3);
    check_bit(open_line, 1'b0);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    repeat (16) @(negedge clk_sys_in);
    rst_in = 1'b0;
    @(negedge clk_sys_in);
    check_code(col, 7'h00);
    check_code(code, 7'h00);
    t_graphic();
    t_functions();
    t_phase();
    t_back_to_back();
    t_end_of_line();
    t_frame();
    t_parity();
    t_open();
    final_report();
  end
endmodule // start_stop_char_receiver_tb_top
